// ===== logic/fbio_cfg.svh
// object indices, field positions, codes and reset values
// assumes inclusion by bare name from every design file that needs them
`ifndef FBIO_CFG_SVH
`define FBIO_CFG_SVH

// object indices
`define IDX_OUT_MAP 16'h1600
`define IDX_IN_MAP 16'h1a00
`define IDX_STAT_MAP 16'h1a01
`define IDX_POLICY 16'h2100
`define IDX_PATTERN 16'h2102
`define IDX_FACTORY 16'h2f00
`define IDX_IN_BYTE 16'h4000
`define IDX_STATUS 16'h4001
`define IDX_OUT_BYTE 16'h5000

// subindices and entry counts
`define SUB_COUNT 8'h00
`define SUB_ENTRY 8'h01
`define ENTRY_COUNT 32'h0000_0001

// mapping descriptor fields
`define MAP_INDEX_MSB 31
`define MAP_INDEX_LSB 16
`define MAP_SUB_MSB 15
`define MAP_SUB_LSB 8
`define MAP_LEN_MSB 7
`define MAP_LEN_LSB 0
`define MAP_LEN_BYTE 8'h08
`define MAP_LEN_WORD 8'h20

// fail-safe policy codes
`define POLICY_LOW 8'h00
`define POLICY_HIGH 8'h01
`define POLICY_HOLD 8'h02
`define POLICY_PATTERN 8'h03
`define POLICY_RESET 8'h00
`define PATTERN_RESET 8'h00

// factory restore codes
`define FACTORY_NORMAL 8'h00
`define FACTORY_RESTORE 8'h01

// link state codes and status codes
`define ST_INIT 4'h1
`define ST_PREOP 4'h2
`define ST_BOOT 4'h3
`define ST_SAFEOP 4'h4
`define ST_OP 4'h8
`define ERR_FLAG_BIT 4
`define CODE_NONE 16'h0000
`define CODE_BAD_CHANGE 16'h0011
`define CODE_UNKNOWN 16'h0012
`define CODE_BAD_OUTPUT 16'h001d

// status word
`define DIAG_BITS 6
`define DIAG_OUT_SHORT 0
`define DIAG_OUT_SURGE 1
`define DIAG_ACT_OVERLOAD 2
`define DIAG_ACT_UNDERVOLT 3
`define DIAG_SENS_SURGE 4
`define DIAG_SENS_UNDERVOLT 5

`endif

// ===== logic/fbio_pkg.sv
// types shared by the process image and fail-safe logic
// assumes nothing of its surroundings
`default_nettype none

package fbio_pkg;
   typedef logic [7:0] io_byte_t;
   typedef enum logic [2:0] {LS_INIT, LS_PREOP, LS_BOOT, LS_SAFEOP, LS_OP} link_state_t;
   typedef enum logic [1:0] {ARB_IDLE, ARB_MBX, ARB_STATE} arb_state_t;
endpackage

`default_nettype wire

// ===== logic/work_arbiter.sv
// picks between pending mailbox work and state-change work
// assumes pending flags stay high until their grant
`timescale 1ns/1ns
`default_nettype none

module work_arbiter
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic mbx_pending,
   input wire logic state_pending,
   output logic grant_mbx,
   output logic grant_state
);
   import fbio_pkg::*;

   arb_state_t arb;
   arb_state_t next_arb;

   always_comb
   begin
      next_arb = ARB_IDLE;
      case (arb)
         ARB_IDLE:
         begin
            if (mbx_pending)
               next_arb = ARB_MBX;
            else if (state_pending)
               next_arb = ARB_STATE;
         end
         ARB_MBX: next_arb = ARB_IDLE;
         ARB_STATE: next_arb = ARB_IDLE;
         default: next_arb = ARB_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         arb <= ARB_IDLE;
      else
         arb <= next_arb;
   end

   assign grant_mbx = (arb == ARB_MBX);
   assign grant_state = (arb == ARB_STATE);
endmodule // work_arbiter

`default_nettype wire

// ===== logic/failsafe_mux.sv
// chooses the output byte from master data or fail-safe policy
// assumes the caller registers the result
`timescale 1ns/1ns
`default_nettype none
`include "fbio_cfg.svh"

module failsafe_mux
(
   input wire logic use_master,
   input wire fbio_pkg::io_byte_t master_byte,
   input wire fbio_pkg::io_byte_t policy,
   input wire fbio_pkg::io_byte_t pattern,
   input wire fbio_pkg::io_byte_t last_out,
   output fbio_pkg::io_byte_t out_byte
);
   import fbio_pkg::*;

   always_comb
   begin
      out_byte = 8'h00;
      if (use_master)
         out_byte = master_byte;
      else
      begin
         case (policy)
            `POLICY_LOW: out_byte = 8'h00;
            `POLICY_HIGH: out_byte = 8'hff;
            `POLICY_HOLD: out_byte = last_out;
            `POLICY_PATTERN: out_byte = pattern;
            default: out_byte = 8'h00;
         endcase
      end
   end
endmodule // failsafe_mux

`default_nettype wire

// ===== logic/fieldbus_io_process_image_failsafe.sv
// process image, object access and fail-safe outputs
// assumes one clock; requests are one-cycle pulses from logic on the same clock
`timescale 1ns/1ns
`default_nettype none
`include "fbio_cfg.svh"

// What this block does
// - a mailbox request is finished before any other pending work starts
// - master and device may touch the shared process image at any time
// - image words update whole in one cycle, so no access is torn
// - outside operational, outputs come from the fail-safe policy
// - policy 00 low, 01 high, 02 hold last, 03 substitute pattern
// - substitute pattern acts only under policy 03
// - policy and pattern accept writes only in pre-operational
// - factory control: 00 normal, 01 restore, other values reserved
// - factory restore takes effect only at the next restart
// - each cycle's input image carries the byte plus a 4-byte status word
// - descriptor packs index 31:16, subindex 15:8, bit length 7:0
// - one entry per map: 5000/01/8, 4000/01/8, 4001/01/32
// - input 1 sits in bit 0, input 8 in bit 7
// - output 1 driven from bit 0, output 8 from bit 7
// - status bit 5 sensor undervoltage, bit 4 sensor surge
// - status bits 3..0: actuator undervolt, overload, output surge, short
// - current link state code is reported; 02 pre-op, 08 operational
// - bad output config in op or safe-op drops to safe-op, error 001d
module fieldbus_io_process_image_failsafe
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic restart,
   input wire fbio_pkg::io_byte_t din_pin,
   input wire logic [5:0] diag_pin,
   output fbio_pkg::io_byte_t dout,
   input wire logic pd_cycle,
   input wire fbio_pkg::io_byte_t pd_out_byte,
   output fbio_pkg::io_byte_t pd_in_byte,
   output logic [31:0] pd_in_status,
   input wire logic state_req_valid,
   input wire logic [3:0] state_req_code,
   output logic state_req_done,
   input wire logic out_cfg_bad,
   input wire logic mbx_req_valid,
   input wire logic mbx_req_write,
   input wire logic [15:0] mbx_req_index,
   input wire logic [7:0] mbx_req_subindex,
   input wire fbio_pkg::io_byte_t mbx_req_wdata,
   output logic mbx_resp_valid,
   output logic mbx_resp_error,
   output logic [31:0] mbx_resp_rdata,
   output logic [15:0] link_state_report,
   output logic [15:0] link_status_code
);
   import fbio_pkg::*;

   function automatic logic [31:0] map_descriptor(input logic [15:0] idx, input logic [7:0] len);
      logic [31:0] d;
      d = 32'h0000_0000;
      d[`MAP_INDEX_MSB:`MAP_INDEX_LSB] = idx;
      d[`MAP_SUB_MSB:`MAP_SUB_LSB] = `SUB_ENTRY;
      d[`MAP_LEN_MSB:`MAP_LEN_LSB] = len;
      return d;
   endfunction

   function automatic logic [3:0] state_code(input link_state_t s);
      case (s)
         LS_INIT: return `ST_INIT;
         LS_PREOP: return `ST_PREOP;
         LS_BOOT: return `ST_BOOT;
         LS_SAFEOP: return `ST_SAFEOP;
         LS_OP: return `ST_OP;
         default: return `ST_INIT;
      endcase
   endfunction

   // pin synchronisers
   io_byte_t din_meta;
   io_byte_t din_sync;
   logic [5:0] diag_meta;
   logic [5:0] diag_sync;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         din_meta <= 8'h00;
         din_sync <= 8'h00;
         diag_meta <= 6'h00;
         diag_sync <= 6'h00;
      end
      else
      begin
         din_meta <= din_pin;
         din_sync <= din_meta;
         diag_meta <= diag_pin;
         diag_sync <= diag_meta;
      end
   end

   // request capture
   logic mbx_pending, next_mbx_pending;
   logic state_pending, next_state_pending;
   logic req_write, next_req_write;
   logic [15:0] req_index, next_req_index;
   logic [7:0] req_sub, next_req_sub;
   io_byte_t req_wdata, next_req_wdata;
   logic [3:0] req_code, next_req_code;
   logic grant_mbx;
   logic grant_state;

   work_arbiter arbiter
   (
      .clk(clk),
      .reset_n(reset_n),
      .mbx_pending(mbx_pending),
      .state_pending(state_pending),
      .grant_mbx(grant_mbx),
      .grant_state(grant_state)
   );

   always_comb
   begin
      next_req_write = req_write;
      next_req_index = req_index;
      next_req_sub = req_sub;
      next_req_wdata = req_wdata;
      next_req_code = req_code;
      next_mbx_pending = mbx_pending & ~grant_mbx;
      next_state_pending = state_pending & ~grant_state;
      if (mbx_req_valid && !mbx_pending)
      begin
         next_mbx_pending = 1'b1;
         next_req_write = mbx_req_write;
         next_req_index = mbx_req_index;
         next_req_sub = mbx_req_subindex;
         next_req_wdata = mbx_req_wdata;
      end
      if (state_req_valid && !state_pending)
      begin
         next_state_pending = 1'b1;
         next_req_code = state_req_code;
      end
      if (restart)
      begin
         next_mbx_pending = 1'b0;
         next_state_pending = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         mbx_pending <= 1'b0;
         state_pending <= 1'b0;
         req_write <= 1'b0;
         req_index <= 16'h0000;
         req_sub <= 8'h00;
         req_wdata <= 8'h00;
         req_code <= 4'h0;
      end
      else
      begin
         mbx_pending <= next_mbx_pending;
         state_pending <= next_state_pending;
         req_write <= next_req_write;
         req_index <= next_req_index;
         req_sub <= next_req_sub;
         req_wdata <= next_req_wdata;
         req_code <= next_req_code;
      end
   end

   // link state machine
   link_state_t link_state, next_link_state;
   link_state_t target;
   logic target_known;
   logic change_bad;
   logic link_error, next_link_error;
   logic [15:0] next_status_code;
   logic next_state_done;

   always_comb
   begin
      target = LS_INIT;
      target_known = 1'b1;
      case (req_code)
         `ST_INIT: target = LS_INIT;
         `ST_PREOP: target = LS_PREOP;
         `ST_BOOT: target = LS_BOOT;
         `ST_SAFEOP: target = LS_SAFEOP;
         `ST_OP: target = LS_OP;
         default: target_known = 1'b0;
      endcase
      change_bad = (link_state == LS_INIT && (target == LS_SAFEOP || target == LS_OP))
         || (link_state == LS_PREOP && target == LS_OP)
         || (target == LS_BOOT && link_state != LS_INIT && link_state != LS_BOOT);
      next_link_state = link_state;
      next_link_error = link_error;
      next_status_code = link_status_code;
      next_state_done = 1'b0;
      if (restart)
      begin
         next_link_state = LS_INIT;
         next_link_error = 1'b0;
         next_status_code = `CODE_NONE;
      end
      // bad output config in op or safe-op
      else if (out_cfg_bad && (link_state == LS_OP || link_state == LS_SAFEOP))
      begin
         next_link_state = LS_SAFEOP;
         next_link_error = 1'b1;
         next_status_code = `CODE_BAD_OUTPUT;
      end
      else if (grant_state)
      begin
         next_state_done = 1'b1;
         next_link_error = 1'b1;
         if (!target_known)
            next_status_code = `CODE_UNKNOWN;
         else if (change_bad)
            next_status_code = `CODE_BAD_CHANGE;
         else if (link_state == LS_PREOP && target == LS_SAFEOP && out_cfg_bad)
            next_status_code = `CODE_BAD_OUTPUT;
         else
         begin
            next_link_state = target;
            next_link_error = 1'b0;
            next_status_code = `CODE_NONE;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         link_state <= LS_INIT;
         link_error <= 1'b0;
         link_status_code <= `CODE_NONE;
         state_req_done <= 1'b0;
         link_state_report <= {12'h000, `ST_INIT};
      end
      else
      begin
         link_state <= next_link_state;
         link_error <= next_link_error;
         link_status_code <= next_status_code;
         state_req_done <= next_state_done;
         // report state code and error flag
         link_state_report <= {11'h000, next_link_error, state_code(next_link_state)};
      end
   end

   // object access and configuration
   io_byte_t policy, next_policy;
   io_byte_t pattern, next_pattern;
   io_byte_t factory, next_factory;
   logic next_resp_valid;
   logic next_resp_error;
   logic [31:0] next_resp_rdata;
   logic preop;

   always_comb
   begin
      preop = (link_state == LS_PREOP);
      next_policy = policy;
      next_pattern = pattern;
      next_factory = factory;
      next_resp_valid = 1'b0;
      next_resp_error = 1'b0;
      next_resp_rdata = 32'h0000_0000;
      if (restart)
      begin
         if (factory == `FACTORY_RESTORE)
         begin
            next_policy = `POLICY_RESET;
            next_pattern = `PATTERN_RESET;
            next_factory = `FACTORY_NORMAL;
         end
      end
      else if (grant_mbx)
      begin
         next_resp_valid = 1'b1;
         next_resp_error = 1'b1;
         if (req_write)
         begin
            if (req_index == `IDX_POLICY && req_sub == `SUB_COUNT && preop && req_wdata <= `POLICY_PATTERN)
            begin
               next_policy = req_wdata;
               next_resp_error = 1'b0;
            end
            else if (req_index == `IDX_PATTERN && req_sub == `SUB_ENTRY && preop)
            begin
               next_pattern = req_wdata;
               next_resp_error = 1'b0;
            end
            else if (req_index == `IDX_FACTORY && req_sub == `SUB_COUNT
               && (req_wdata == `FACTORY_NORMAL || req_wdata == `FACTORY_RESTORE))
            begin
               next_factory = req_wdata;
               next_resp_error = 1'b0;
            end
         end
         else if (req_sub == `SUB_COUNT && (req_index == `IDX_OUT_MAP || req_index == `IDX_IN_MAP
            || req_index == `IDX_STAT_MAP || req_index == `IDX_PATTERN || req_index == `IDX_IN_BYTE
            || req_index == `IDX_STATUS || req_index == `IDX_OUT_BYTE))
         begin
            next_resp_rdata = `ENTRY_COUNT;
            next_resp_error = 1'b0;
         end
         else if (req_sub == `SUB_COUNT && (req_index == `IDX_POLICY || req_index == `IDX_FACTORY))
         begin
            next_resp_rdata = {24'h000000, (req_index == `IDX_POLICY) ? policy : factory};
            next_resp_error = 1'b0;
         end
         else if (req_sub == `SUB_ENTRY)
         begin
            next_resp_error = 1'b0;
            case (req_index)
               `IDX_OUT_MAP: next_resp_rdata = map_descriptor(`IDX_OUT_BYTE, `MAP_LEN_BYTE);
               `IDX_IN_MAP: next_resp_rdata = map_descriptor(`IDX_IN_BYTE, `MAP_LEN_BYTE);
               `IDX_STAT_MAP: next_resp_rdata = map_descriptor(`IDX_STATUS, `MAP_LEN_WORD);
               `IDX_PATTERN: next_resp_rdata = {24'h000000, pattern};
               `IDX_IN_BYTE: next_resp_rdata = {24'h000000, pd_in_byte};
               `IDX_STATUS: next_resp_rdata = pd_in_status;
               `IDX_OUT_BYTE: next_resp_rdata = {24'h000000, dout};
               default: next_resp_error = 1'b1;
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         policy <= `POLICY_RESET;
         pattern <= `PATTERN_RESET;
         factory <= `FACTORY_NORMAL;
         mbx_resp_valid <= 1'b0;
         mbx_resp_error <= 1'b0;
         mbx_resp_rdata <= 32'h0000_0000;
      end
      else
      begin
         policy <= next_policy;
         pattern <= next_pattern;
         factory <= next_factory;
         mbx_resp_valid <= next_resp_valid;
         mbx_resp_error <= next_resp_error;
         mbx_resp_rdata <= next_resp_rdata;
      end
   end

   // process image and outputs
   io_byte_t master_byte, next_master_byte;
   logic fresh, next_fresh;
   io_byte_t next_pd_in_byte;
   logic [31:0] next_pd_in_status;
   io_byte_t next_dout;

   always_comb
   begin
      next_master_byte = master_byte;
      next_pd_in_byte = pd_in_byte;
      next_pd_in_status = pd_in_status;
      next_fresh = fresh;
      if (pd_cycle)
      begin
         next_pd_in_byte = din_sync;
         next_pd_in_status = {26'h0000000, diag_sync};
         if (link_state == LS_OP)
         begin
            next_master_byte = pd_out_byte;
            next_fresh = 1'b1;
         end
      end
      // wait for first cycle after entering op
      if (next_link_state != LS_OP || link_state != LS_OP)
         next_fresh = (next_link_state == LS_OP) && (link_state == LS_OP) && next_fresh;
   end

   failsafe_mux out_select
   (
      .use_master(fresh && link_state == LS_OP),
      .master_byte(master_byte),
      .policy(policy),
      .pattern(pattern),
      .last_out(dout),
      .out_byte(next_dout)
   );

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         master_byte <= 8'h00;
         fresh <= 1'b0;
         pd_in_byte <= 8'h00;
         pd_in_status <= 32'h0000_0000;
         dout <= 8'h00;
      end
      else
      begin
         master_byte <= next_master_byte;
         fresh <= next_fresh;
         pd_in_byte <= next_pd_in_byte;
         pd_in_status <= next_pd_in_status;
         dout <= next_dout;
      end
   end
endmodule // fieldbus_io_process_image_failsafe

`default_nettype wire

// ===== testbench/fbio_checker_assertions.sv
// port timing checks for the process image block
// assumes a bind onto fieldbus_io_process_image_failsafe
`timescale 1ns/1ns
`default_nettype none

module fbio_checker
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic restart,
   input wire logic [7:0] din_pin,
   input wire logic [5:0] diag_pin,
   input wire logic [7:0] dout,
   input wire logic pd_cycle,
   input wire logic [7:0] pd_out_byte,
   input wire logic [7:0] pd_in_byte,
   input wire logic [31:0] pd_in_status,
   input wire logic state_req_valid,
   input wire logic [3:0] state_req_code,
   input wire logic state_req_done,
   input wire logic out_cfg_bad,
   input wire logic mbx_req_valid,
   input wire logic mbx_req_write,
   input wire logic [15:0] mbx_req_index,
   input wire logic [7:0] mbx_req_wdata,
   input wire logic mbx_resp_valid,
   input wire logic mbx_resp_error,
   input wire logic [15:0] link_state_report,
   input wire logic [15:0] link_status_code
);
   logic busy;
   wire logic op = link_state_report[3:0] == 4'h8;
   wire logic wr_new = mbx_req_valid && mbx_req_write && !busy;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   // outstanding object access
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         busy <= 1'b0;
      else if (mbx_resp_valid || restart)
         busy <= 1'b0;
      else if (mbx_req_valid)
         busy <= 1'b1;
   end

   property p_mbx_answer;
      disable iff (!reset_n || restart) mbx_req_valid && !busy |-> ##3 mbx_resp_valid;
   endproperty
   a_mbx_answer: assert property (p_mbx_answer) else $error("object answer late");
   property p_mbx_first;
      disable iff (!reset_n || restart) mbx_req_valid && state_req_valid && !busy |-> ##3 mbx_resp_valid && !state_req_done;
   endproperty
   a_mbx_first: assert property (p_mbx_first) else $error("state before object");
   property p_in_image;
      pd_cycle |=> pd_in_byte == $past(din_pin, 3) && pd_in_status == {26'h0, $past(diag_pin, 3)};
   endproperty
   a_in_image: assert property (p_in_image) else $error("input image wrong");
   property p_dout_follow;
      pd_cycle && op && !out_cfg_bad ##1 op && !out_cfg_bad |=> dout == $past(pd_out_byte, 2);
   endproperty
   a_dout_follow: assert property (p_dout_follow) else $error("dout not master");
   property p_state_done;
      state_req_valid && !mbx_req_valid && !busy |-> ##3 state_req_done;
   endproperty
   a_state_done: assert property (p_state_done) else $error("state request not done");
   property p_report;
      $past(state_req_valid, 3) && state_req_done && link_status_code == 16'h0000
         |-> link_state_report == {12'h000, $past(state_req_code, 3)};
   endproperty
   a_report: assert property (p_report) else $error("state report wrong");
   property p_cfg_bad;
      out_cfg_bad && (op || link_state_report[3:0] == 4'h4) |=> link_state_report == 16'h0014 && link_status_code == 16'h001d;
   endproperty
   a_cfg_bad: assert property (p_cfg_bad) else $error("bad config missed");
   property p_policy_lock;
      disable iff (!reset_n || restart) wr_new && (mbx_req_index == 16'h2100 || mbx_req_index == 16'h2102)
         && link_state_report[3:0] != 4'h2 |-> ##3 mbx_resp_valid && mbx_resp_error;
   endproperty
   a_policy_lock: assert property (p_policy_lock) else $error("policy write taken outside pre-op");
   property p_factory_code;
      disable iff (!reset_n || restart) wr_new && mbx_req_index == 16'h2f00 && mbx_req_wdata > 8'h01
         |-> ##3 mbx_resp_valid && mbx_resp_error;
   endproperty
   a_factory_code: assert property (p_factory_code) else $error("reserved code taken");
endmodule // fbio_checker

bind fieldbus_io_process_image_failsafe fbio_checker fbio_checker_inst (.*);

`default_nettype wire

// ===== testbench/master_model.sv
// far-side master issuing object, state and cyclic traffic
// assumes the block samples on the rising edge; drives on the falling edge
`timescale 1ns/1ns
`default_nettype none

module master_model
(
   input wire logic clk,
   output var logic pd_cycle,
   output var fbio_pkg::io_byte_t pd_out_byte,
   output var logic state_req_valid,
   output var logic [3:0] state_req_code,
   input wire logic state_req_done,
   output var logic mbx_req_valid,
   output var logic mbx_req_write,
   output var logic [15:0] mbx_req_index,
   output var logic [7:0] mbx_req_subindex,
   output var fbio_pkg::io_byte_t mbx_req_wdata,
   input wire logic mbx_resp_valid,
   input wire logic mbx_resp_error,
   input wire logic [31:0] mbx_resp_rdata
);
   import fbio_pkg::*;
   initial
   begin
      pd_cycle = 1'b0;
      pd_out_byte = 8'h00;
      state_req_valid = 1'b0;
      state_req_code = 4'h0;
      mbx_req_valid = 1'b0;
      mbx_req_write = 1'b0;
      mbx_req_index = 16'h0000;
      mbx_req_subindex = 8'h00;
      mbx_req_wdata = 8'h00;
   end

   task automatic obj(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input io_byte_t wd,
      output logic [31:0] rd, output logic er);
      @(negedge clk);
      mbx_req_valid = 1'b1;
      mbx_req_write = wr;
      mbx_req_index = idx;
      mbx_req_subindex = sub;
      mbx_req_wdata = wd;
      @(negedge clk);
      mbx_req_valid = 1'b0;
      mbx_req_index = ~idx;
      mbx_req_subindex = ~sub;
      mbx_req_wdata = ~wd;
      for (int n = 0; n < 8 && mbx_resp_valid !== 1'b1; n++)
         @(negedge clk);
      rd = mbx_resp_rdata;
      er = mbx_resp_valid ? mbx_resp_error : 1'bx;
   endtask

   task automatic req_state(input logic [3:0] code);
      @(negedge clk);
      state_req_valid = 1'b1;
      state_req_code = code;
      @(negedge clk);
      state_req_valid = 1'b0;
      state_req_code = ~code;
      for (int n = 0; n < 8 && state_req_done !== 1'b1; n++)
         @(negedge clk);
   endtask

   task automatic cycle(input io_byte_t b);
      @(negedge clk);
      pd_cycle = 1'b1;
      pd_out_byte = b;
      @(negedge clk);
      pd_cycle = 1'b0;
      pd_out_byte = ~b;
      @(negedge clk);
   endtask
endmodule // master_model

`default_nettype wire

// ===== testbench/test_fieldbus_io_process_image_failsafe.sv
// self-checking bench for the process image block
// assumes master_model on the far side and the checker bound to the design
`timescale 1ns/1ns
`default_nettype none

module test_fieldbus_io_process_image_failsafe;
   import fbio_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic restart = 1'b0;
   logic out_cfg_bad = 1'b0;
   io_byte_t din_pin = 8'h00;
   logic [5:0] diag_pin = 6'h00;
   logic pd_cycle, state_req_valid, state_req_done, mbx_req_valid, mbx_req_write, mbx_resp_valid, mbx_resp_error, e;
   io_byte_t dout, pd_out_byte, pd_in_byte, mbx_req_wdata;
   logic [3:0] state_req_code;
   logic [7:0] mbx_req_subindex;
   logic [15:0] mbx_req_index, link_state_report, link_status_code;
   logic [31:0] pd_in_status, mbx_resp_rdata, d;
   io_byte_t fs [4] = '{8'h00, 8'hff, 8'h5a, 8'h3c};
   int err_count = 0;
   int checked = 0;
   int cycles = 0;

   always #50 clk = ~clk;

   fieldbus_io_process_image_failsafe fieldbus_io_process_image_failsafe_inst (.clk, .reset_n, .restart, .din_pin,
      .diag_pin, .dout, .pd_cycle, .pd_out_byte, .pd_in_byte, .pd_in_status, .state_req_valid, .state_req_code,
      .state_req_done, .out_cfg_bad, .mbx_req_valid, .mbx_req_write, .mbx_req_index, .mbx_req_subindex,
      .mbx_req_wdata, .mbx_resp_valid, .mbx_resp_error, .mbx_resp_rdata, .link_state_report, .link_status_code);
   master_model master_model_inst (.*);

   task automatic wrap_up();
      $display("checked %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_count++;
         wrap_up();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp, input logic er);
      master_model_inst.obj(1'b0, idx, sub, 8'h00, d, e);
      check(d, exp);
      check(e, er);
   endtask

   task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input io_byte_t v, input logic er);
      master_model_inst.obj(1'b1, idx, sub, v, d, e);
      check(e, er);
   endtask

   task automatic st(input logic [3:0] c, input logic [15:0] rep, input logic [15:0] code);
      master_model_inst.req_state(c);
      check(link_state_report, rep);
      check(link_status_code, code);
   endtask

   initial
   begin
      repeat (10) @(negedge clk);
      reset_n = 1'b1;
      check(dout, 8'h00);
      check(link_state_report, 16'h0001);
      rd(16'h1600, 8'h01, 32'h5000_0108, 1'b0);
      rd(16'h1a00, 8'h01, 32'h4000_0108, 1'b0);
      rd(16'h1a01, 8'h01, 32'h4001_0120, 1'b0);
      rd(16'h1a01, 8'h00, 32'h0000_0001, 1'b0);
      rd(16'h2100, 8'h00, 32'h0000_0000, 1'b0);
      rd(16'h2f00, 8'h00, 32'h0000_0000, 1'b0);
      rd(16'h3000, 8'h00, 32'h0000_0000, 1'b1);
      $display("objects done");
      din_pin = 8'h81;
      diag_pin = 6'h2a;
      repeat (3) @(negedge clk);
      master_model_inst.cycle(8'h77);
      check(pd_in_byte, 8'h81);
      check(pd_in_status, 32'h0000_002a);
      check(dout, 8'h00);
      $display("image done");
      st(4'h8, 16'h0011, 16'h0011);
      st(4'h5, 16'h0011, 16'h0012);
      wr(16'h2100, 8'h00, 8'h01, 1'b1);
      st(4'h2, 16'h0002, 16'h0000);
      wr(16'h2100, 8'h00, 8'h04, 1'b1);
      wr(16'h2f00, 8'h00, 8'h02, 1'b1);
      $display("states done");
      for (int p = 0; p < 4; p++)
      begin
         wr(16'h2100, 8'h00, p[7:0], 1'b0);
         wr(16'h2102, 8'h01, 8'h3c, 1'b0);
         st(4'h4, 16'h0004, 16'h0000);
         master_model_inst.cycle(8'hc3);
         check(dout, (p == 2) ? 8'hff : fs[p]);
         st(4'h8, 16'h0008, 16'h0000);
         check(dout, (p == 2) ? 8'hff : fs[p]);
         wr(16'h2102, 8'h01, 8'h11, 1'b1);
         master_model_inst.cycle(8'h5a);
         check(dout, 8'h5a);
         @(negedge clk) out_cfg_bad = 1'b1;
         @(negedge clk) out_cfg_bad = 1'b0;
         @(negedge clk);
         check(link_status_code, 16'h001d);
         check(dout, fs[p]);
         st(4'h2, 16'h0002, 16'h0000);
      end
      $display("failsafe done");
      fork
         rd(16'h2100, 8'h00, 32'h0000_0003, 1'b0);
         master_model_inst.req_state(4'h4);
      join
      check(link_state_report, 16'h0004);
      wr(16'h2f00, 8'h00, 8'h01, 1'b0);
      rd(16'h2f00, 8'h00, 32'h0000_0001, 1'b0);
      rd(16'h2100, 8'h00, 32'h0000_0003, 1'b0);
      @(negedge clk) restart = 1'b1;
      @(negedge clk) restart = 1'b0;
      @(negedge clk);
      check(link_state_report, 16'h0001);
      rd(16'h2100, 8'h00, 32'h0000_0000, 1'b0);
      rd(16'h2102, 8'h01, 32'h0000_0000, 1'b0);
      rd(16'h2f00, 8'h00, 32'h0000_0000, 1'b0);
      $display("restore done");
      wrap_up();
   end
endmodule // test_fieldbus_io_process_image_failsafe

`default_nettype wire
